// >>> design/spfc_port.sv
`timescale 1ns/100ps
// Functional notes
// - rates 300 to 38400 in doublings, 19200 after reset.
// - 38400 taken only when differential multidrop physical layer is set.
// - odd, even or no parity generated and checked, none by default.
// - seven or eight data bits, eight by default.
// - one or two stop bits transmitted, one by default.
// - one framing setup governs transmit and receive.
// - new configuration accepted while running, no reset needed.
// - hardware flow: raise RTS when data ready, send after CTS.
// - hardware flow: RTS held after last stop bit for release delay.
// - software or no flow: RTS low, transmit without CTS.
// - software flow: XOFF pauses, XON resumes transmission.
// - release delay 0 to 65534 ms from last character end, default 0.
module spfc_port
    import spfc_pkg::*;
#(
    parameter int unsigned MS_CYC = SPFC_MS_CYC,
    parameter int unsigned CLK_HZ = SPFC_CLK_HZ
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic cfg_wr_i,
    input wire logic [2:0] rate_sel_i,
    input wire logic [1:0] parity_sel_i,
    input wire logic char_width_select_i,
    input wire logic stop_bit_count_i,
    input wire logic [1:0] flow_control_select_i,
    input wire logic diff_phy_i,
    input wire logic [15:0] driver_release_delay_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic rxd_i,
    input wire logic cts_i,
    output logic txd_o,
    output logic rts_o,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    output logic rx_perr_o,
    output logic tx_paused_o,
    output logic cfg_reject_o
);
    localparam int unsigned OVS_N = 32'(SPFC_OVS) + 32'h1;
    localparam int unsigned DIV_BASE = CLK_HZ / (SPFC_RATE_BASE * OVS_N);
    if (MS_CYC < 1) begin : g_ms_bad
        $error("MS_CYC must be at least one");
    end
    // top rate needs a divisor of at least one, slowest must fit the counter
    if ((DIV_BASE >> SPFC_RATE_TOP) < 1 || DIV_BASE > 32'h0003ffff) begin : g_clk_bad
        $error("CLK_HZ outside divider range");
    end
    typedef enum logic [4:0] {
        TX_IDLE = 5'h01, TX_WCTS = 5'h02, TX_SHIFT = 5'h04, TX_HOLD = 5'h08,
        TX_LOAD = 5'h10
    } spfc_tx_t;
    spfc_tx_t st_q;
    logic [2:0] rate_q;
    logic [1:0] par_q, flow_q;
    logic w7_q, stop2_q;
    logic [15:0] dly_q;
    logic [1:0] rxs_q, ctss_q;
    logic [17:0] div_q;
    logic [3:0] ovs_q;
    logic [11:0] sh_q;
    logic [3:0] left_q;
    logic [15:0] ms_left_q;
    logic [31:0] mscnt_q;
    logic xoff_q;
    logic [7:0] rxd8;
    logic rxv, rxpe;
    // 16x oversample tick: clk / (rate * 16)
    wire [17:0] div_top = 18'(DIV_BASE >> rate_q) - 18'h1;
    wire tick = (div_q == 18'h0);
    wire btick = tick && (ovs_q == SPFC_OVS);
    wire rate_ok = (rate_sel_i != SPFC_RATE_TOP) || diff_phy_i;
    wire hw = (flow_q == SPFC_FLOW_HW);
    wire par_on = (par_q != SPFC_PAR_NONE);
    wire pbit = ^(w7_q ? {1'b0, tx_data_i[6:0]} : tx_data_i) ^ (par_q == SPFC_PAR_ODD);
    wire [7:0] dmask = w7_q ? {1'b0, tx_data_i[6:0]} : tx_data_i;
    // frame lsb first: start, data, parity, stops, idle-high fill
    wire [11:0] frame_w7 = par_on ? {3'h7, pbit, dmask[6:0], 1'b0}
                                  : {4'hf, dmask[6:0], 1'b0};
    wire [11:0] frame_w8 = par_on ? {2'h3, pbit, dmask, 1'b0} : {3'h7, dmask, 1'b0};
    wire [3:0] nbits = 4'h1 + (w7_q ? 4'h7 : 4'h8) + {3'h0, par_on}
                     + (stop2_q ? 4'h2 : 4'h1);
    wire may_go = hw ? ctss_q[1] : !((flow_q == SPFC_FLOW_SW) && xoff_q);
    wire ms_tick = (mscnt_q == MS_CYC - 1);
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            rate_q <= SPFC_RATE_RST;
            par_q <= SPFC_PAR_NONE;
            w7_q <= 1'b0;
            stop2_q <= 1'b0;
            flow_q <= SPFC_FLOW_HW;
            dly_q <= SPFC_DELAY_RST;
            cfg_reject_o <= 1'b0;
        end else if (cfg_wr_i) begin
            // live reconfiguration
            cfg_reject_o <= !rate_ok;
            if (rate_ok) rate_q <= rate_sel_i;
            if (parity_sel_i <= SPFC_PAR_EVEN) par_q <= parity_sel_i;
            w7_q <= char_width_select_i;
            stop2_q <= stop_bit_count_i;
            if (flow_control_select_i <= SPFC_FLOW_NONE) flow_q <= flow_control_select_i;
            dly_q <= (driver_release_delay_i > SPFC_DELAY_MAX) ? SPFC_DELAY_MAX
                     : driver_release_delay_i;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            rxs_q <= 2'h3;
            ctss_q <= 2'h0;
            div_q <= 18'h0;
            ovs_q <= 4'h0;
            xoff_q <= 1'b0;
        end else begin
            rxs_q <= {rxs_q[0], rxd_i};
            ctss_q <= {ctss_q[0], cts_i};
            div_q <= tick ? div_top : div_q - 18'h1;
            if (tick) ovs_q <= ovs_q + 4'h1;
            if (rxv && flow_q == SPFC_FLOW_SW && rxd8 == SPFC_XOFF) xoff_q <= 1'b1;
            else if ((rxv && rxd8 == SPFC_XON) || flow_q != SPFC_FLOW_SW) xoff_q <= 1'b0;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            st_q <= TX_IDLE;
            sh_q <= 12'hfff;
            left_q <= 4'h0;
            ms_left_q <= 16'h0;
            mscnt_q <= 32'h0;
            txd_o <= 1'b1;
            rts_o <= 1'b0;
            tx_ready_o <= 1'b0;
            tx_paused_o <= 1'b0;
        end else begin
            tx_ready_o <= 1'b0;
            tx_paused_o <= (flow_q == SPFC_FLOW_SW) && xoff_q;
            mscnt_q <= ms_tick ? 32'h0 : mscnt_q + 32'h1;
            case (st_q)
                TX_IDLE, TX_HOLD: begin
                    if (tx_valid_i && !tx_ready_o) begin
                        rts_o <= hw;
                        st_q <= TX_WCTS;
                    end else if (st_q == TX_HOLD) begin
                        // rts held for release delay
                        if (ms_left_q == 16'h0) begin
                            rts_o <= 1'b0;
                            st_q <= TX_IDLE;
                        end else if (ms_tick) ms_left_q <= ms_left_q - 16'h1;
                    end
                end
                TX_WCTS: begin
                    // follows a flow change made while waiting
                    rts_o <= hw;
                    if (may_go && btick) begin
                        sh_q <= w7_q ? frame_w7 : frame_w8;
                        left_q <= nbits;
                        tx_ready_o <= 1'b1;
                        st_q <= TX_SHIFT;
                    end
                end
                TX_SHIFT: if (btick) begin
                    txd_o <= sh_q[0];
                    sh_q <= {1'b1, sh_q[11:1]};
                    left_q <= left_q - 4'h1;
                    if (left_q == 4'h0) st_q <= TX_LOAD;
                end
                TX_LOAD: begin
                    txd_o <= 1'b1;
                    ms_left_q <= dly_q;
                    mscnt_q <= 32'h0;
                    st_q <= hw ? TX_HOLD : TX_IDLE;
                end
                default: st_q <= TX_IDLE;
            endcase
        end
    end
    spfc_rx u_rx (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .tick_i(tick),
        .rxd_i(rxs_q[1]),
        .wid7_i(w7_q),
        .par_i(par_q),
        .data_o(rxd8),
        .valid_o(rxv),
        .perr_o(rxpe)
    );
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            rx_data_o <= 8'h00;
            rx_valid_o <= 1'b0;
            rx_perr_o <= 1'b0;
        end else begin
            rx_data_o <= rxd8;
            rx_valid_o <= rxv;
            rx_perr_o <= rxpe;
        end
    end
    a_rts_off_soft: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (flow_q != SPFC_FLOW_HW) && st_q == TX_WCTS |=> !rts_o)
        else $error("rts raised without hardware flow");
    a_start_needs_cts: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        st_q == TX_WCTS && $past(st_q) == TX_WCTS && hw && !ctss_q[1] |=> st_q != TX_SHIFT)
        else $error("sent without cts");
    a_ready_after_cts: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        tx_ready_o && $past(hw) |-> $past(ctss_q[1]))
        else $error("frame latched without cts");
    a_rts_held: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        st_q == TX_HOLD && ms_left_q != 16'h0 |=> rts_o)
        else $error("rts dropped early");
    a_xoff_stall: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        flow_q == SPFC_FLOW_SW && xoff_q && st_q == TX_WCTS |=> st_q == TX_WCTS)
        else $error("sent while paused");
    a_rate_guard: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        cfg_wr_i && rate_sel_i == SPFC_RATE_TOP && !diff_phy_i |=> $stable(rate_q))
        else $error("top rate taken single ended");
    a_cfg_live: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        cfg_wr_i |=> w7_q == $past(char_width_select_i))
        else $error("config not applied");
    a_delay_cap: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        dly_q <= SPFC_DELAY_MAX)
        else $error("delay above max");
    a_idle_high: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        st_q == TX_IDLE |-> txd_o)
        else $error("line not idle");
    c_hold: cover property (@(posedge mclk_i) disable iff (!nrst_i) st_q == TX_HOLD);
    c_paused: cover property (@(posedge mclk_i) disable iff (!nrst_i) tx_paused_o);
    c_rx: cover property (@(posedge mclk_i) disable iff (!nrst_i) rx_valid_o);
    c_perr: cover property (@(posedge mclk_i) disable iff (!nrst_i) rx_perr_o);
endmodule

// >>> design/spfc_pkg.sv
package spfc_pkg;
    localparam int unsigned SPFC_CLK_HZ = 200000000;
    localparam int unsigned SPFC_MS_NS = 1000000;
    localparam int unsigned SPFC_CLK_NS = 5;
    localparam int unsigned SPFC_MS_CYC = SPFC_MS_NS / SPFC_CLK_NS;
    localparam logic [15:0] SPFC_DELAY_MAX = 16'hfffe;
    localparam logic [15:0] SPFC_DELAY_RST = 16'h0000;
    // rate codes: 300 * 2**code
    localparam logic [2:0] SPFC_RATE_RST = 3'h6;
    localparam logic [2:0] SPFC_RATE_TOP = 3'h7;
    localparam int unsigned SPFC_RATE_BASE = 300;
    localparam logic [1:0] SPFC_PAR_NONE = 2'h0;
    localparam logic [1:0] SPFC_PAR_ODD = 2'h1;
    localparam logic [1:0] SPFC_PAR_EVEN = 2'h2;
    localparam logic [1:0] SPFC_FLOW_HW = 2'h0;
    localparam logic [1:0] SPFC_FLOW_SW = 2'h1;
    localparam logic [1:0] SPFC_FLOW_NONE = 2'h2;
    localparam logic [7:0] SPFC_XON = 8'h11;
    localparam logic [7:0] SPFC_XOFF = 8'h13;
    localparam logic [3:0] SPFC_OVS = 4'hf;
    localparam logic [3:0] SPFC_OVS_MID = 4'h7;
endpackage

// >>> design/spfc_rx.sv
`timescale 1ns/100ps
module spfc_rx
    import spfc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic tick_i,
    input wire logic rxd_i,
    input wire logic wid7_i,
    input wire logic [1:0] par_i,
    output logic [7:0] data_o,
    output logic valid_o,
    output logic perr_o
);
    typedef enum logic [3:0] {
        RX_IDLE = 4'h1, RX_START = 4'h2, RX_DATA = 4'h4, RX_STOP = 4'h8
    } spfc_rx_t;
    spfc_rx_t st_q;
    logic [3:0] ovs_q;
    logic [3:0] bit_q;
    logic [8:0] sh_q;
    wire par_on = (par_i != SPFC_PAR_NONE);
    wire [3:0] nbits = (wid7_i ? 4'h7 : 4'h8) + {3'h0, par_on};
    wire mid = tick_i && (ovs_q == SPFC_OVS_MID);
    wire [8:0] shn = {rxd_i, sh_q[8:1]};
    wire [8:0] alig = (nbits == 4'h9) ? sh_q : (nbits == 4'h8) ? {1'b0, sh_q[8:1]}
                    : {2'h0, sh_q[8:2]};
    wire [7:0] dat = wid7_i ? {1'b0, alig[6:0]} : alig[7:0];
    wire pbit = wid7_i ? alig[7] : alig[8];
    wire pcalc = ^dat ^ (par_i == SPFC_PAR_ODD);
    always_ff @(posedge mclk_i) begin
        valid_o <= 1'b0;
        if (!nrst_i) begin
            st_q <= RX_IDLE;
            ovs_q <= 4'h0;
            bit_q <= 4'h0;
            sh_q <= 9'h000;
            data_o <= 8'h00;
            perr_o <= 1'b0;
        end else begin
            if (tick_i) ovs_q <= ovs_q + 4'h1;
            case (st_q)
                RX_IDLE: if (!rxd_i) begin
                    st_q <= RX_START;
                    ovs_q <= 4'h0;
                end
                RX_START: if (mid) st_q <= rxd_i ? RX_IDLE : RX_DATA;
                RX_DATA: if (mid) begin
                    sh_q <= shn;
                    bit_q <= bit_q + 4'h1;
                    if (bit_q + 4'h1 == nbits) st_q <= RX_STOP;
                end
                RX_STOP: if (mid) begin
                    // one config serves both directions
                    data_o <= dat;
                    perr_o <= par_on && (pbit != pcalc);
                    valid_o <= 1'b1;
                    bit_q <= 4'h0;
                    st_q <= RX_IDLE;
                end
                default: st_q <= RX_IDLE;
            endcase
        end
    end
    a_rx_perr_clean: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        valid_o && (par_i == SPFC_PAR_NONE) |-> !perr_o)
        else $error("parity error flagged with parity off");
endmodule

// >>> dv/spfc_far_end.sv
`timescale 1ns/100ps
module spfc_far_end (
    input wire logic txd_i,
    input wire logic rts_i,
    output logic rxd_o,
    output logic cts_o
);
    // top-rate bit with the bench's scaled divider: 32 cycles of 5 ns
    realtime bit_ns = 160.0;
    realtime cts_lag = 2000.0;
    initial begin
        rxd_o = 1'b1;
        cts_o = 1'b0;
    end
    // slow answer: cts follows rts after a lag
    always @(rts_i) cts_o <= #(cts_lag) (rts_i === 1'b1);
    // lsb first, optional parity, stop then idle mark
    task automatic send(input logic [7:0] d, input int nb, input logic [1:0] par,
                        input logic bad);
        logic p;
        p = ^(d & ((nb == 7) ? 8'h7f : 8'hff)) ^ (par == 2'h1) ^ bad;
        rxd_o = 1'b0;
        #(bit_ns);
        for (int i = 0; i < nb; i++) begin
            rxd_o = d[i];
            #(bit_ns);
        end
        if (par != 2'h0) begin
            rxd_o = p;
            #(bit_ns);
        end
        rxd_o = 1'b1;
        #(bit_ns);
    endtask
    // samples each bit of one frame at mid-bit
    task automatic take(input int n, output logic [11:0] f, output logic r);
        f = '0;
        @(negedge txd_i);
        #(bit_ns / 2.0);
        for (int k = 0; k < n; k++) begin
            f[k] = txd_i;
            r = rts_i;
            if (k < n - 1) #(bit_ns);
        end
    endtask
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/100ps
module tb_top
    import spfc_pkg::*;
;
    logic mclk, nrst, cfg_wr, w7, stop2, diff, tx_valid, rdy_seen, gotp, rts_end;
    logic [2:0] rate;
    logic [1:0] par, flow;
    logic [15:0] dly;
    logic [7:0] tx_data, got;
    logic [11:0] fr;
    wire logic rxd, cts, txd, rts, tx_ready, rx_valid, rx_perr, paused, reject;
    wire logic [7:0] rx_data;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    int rx_n, n;

    // scaled clock figure: a top-rate bit lasts 32 cycles
    spfc_port #(.MS_CYC(20), .CLK_HZ(1228800)) uut (.mclk_i(mclk), .nrst_i(nrst), .cfg_wr_i(cfg_wr),
        .rate_sel_i(rate), .parity_sel_i(par), .char_width_select_i(w7),
        .stop_bit_count_i(stop2), .flow_control_select_i(flow), .diff_phy_i(diff),
        .driver_release_delay_i(dly), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
        .tx_ready_o(tx_ready), .rxd_i(rxd), .cts_i(cts), .txd_o(txd), .rts_o(rts),
        .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_perr_o(rx_perr),
        .tx_paused_o(paused), .cfg_reject_o(reject));
    spfc_far_end far (.txd_i(txd), .rts_i(rts), .rxd_o(rxd), .cts_o(cts));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (tx_ready === 1'b1) rdy_seen = 1'b1;
        if (rx_valid === 1'b1) begin
            got = rx_data;
            gotp = rx_perr;
            rx_n++;
        end
        if (cyc == 20000) begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic step;
        @(posedge mclk);
        #1;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic cfg(input logic [2:0] r, input logic [1:0] p, input logic w,
                       input logic s, input logic [1:0] f, input logic d);
        step;
        rate = r;
        par = p;
        w7 = w;
        stop2 = s;
        flow = f;
        diff = d;
        cfg_wr = 1'b1;
        step;
        cfg_wr = 1'b0;
        step;
    endtask

    initial begin
        {nrst, cfg_wr, w7, stop2, diff, tx_valid, rdy_seen} = '0;
        {rate, par, flow, dly} = {3'h6, 2'h0, 2'h0, 16'h0014};
        tx_data = 8'hca;
        rx_n = 0;
        repeat (10) @(posedge mclk);
        #1 nrst = 1'b1;
        step;
        chk({txd, rts, reject, paused}, 4'h8, "reset outputs");
        cfg(3'h7, SPFC_PAR_NONE, 1'b0, 1'b0, SPFC_FLOW_HW, 1'b0);
        chk(reject, 1'b1, "fast rate single ended");
        cfg(3'h7, SPFC_PAR_EVEN, 1'b1, 1'b1, SPFC_FLOW_HW, 1'b1);
        chk(reject, 1'b0, "fast rate differential");
        $display("test config done");
        tx_valid = 1'b1;
        repeat (10) step;
        chk(rts, 1'b1, "rts on data ready");
        chk(rdy_seen, 1'b0, "start before cts");
        fork
            far.take(11, fr, rts_end);
            far.send(8'h35, 7, SPFC_PAR_EVEN, 1'b1);
            begin
                for (n = 0; n < 8000 && rdy_seen !== 1'b1; n++) step;
                tx_valid = 1'b0;
            end
        join
        chk(fr[10:0], {2'b11, 1'b1, 7'h4a, 1'b0}, "tx frame");
        chk(rts_end, 1'b1, "rts during stop");
        for (n = 0; n < 6000 && rx_n == 0; n++) step;
        chk({gotp, got}, {1'b1, 8'h35}, "rx parity error");
        for (n = 0; n < 4000 && rts !== 1'b0; n++) step;
        chk((n > 400) && (n < 440), 1'b1, "rts release time");
        $display("test hw flow done");
        cfg(3'h7, SPFC_PAR_ODD, 1'b1, 1'b0, SPFC_FLOW_SW, 1'b1);
        rx_n = 0;
        rdy_seen = 1'b0;
        far.send(SPFC_XOFF, 7, SPFC_PAR_ODD, 1'b0);
        for (n = 0; n < 600 && rx_n == 0; n++) step;
        chk({paused, gotp, got}, {2'b10, SPFC_XOFF}, "xoff pause");
        tx_valid = 1'b1;
        repeat (200) step;
        chk({rts, rdy_seen}, 2'b00, "paused holds tx");
        far.send(SPFC_XON, 7, SPFC_PAR_ODD, 1'b0);
        for (n = 0; n < 600 && rdy_seen !== 1'b1; n++) step;
        tx_valid = 1'b0;
        chk({paused, rts, rdy_seen}, 3'b001, "xon resumes");
        repeat (400) step;
        cfg(3'h7, SPFC_PAR_NONE, 1'b0, 1'b0, SPFC_FLOW_NONE, 1'b1);
        rdy_seen = 1'b0;
        tx_valid = 1'b1;
        fork
            far.take(10, fr, rts_end);
            begin
                for (n = 0; n < 600 && rdy_seen !== 1'b1; n++) step;
                tx_valid = 1'b0;
            end
        join
        chk({rts, rts_end, n < 40}, 3'b001, "no flow sends at once");
        chk(fr[9:0], {1'b1, 8'hca, 1'b0}, "eight bit frame");
        $display("test sw and no flow done");
        wrap_up();
    end
endmodule
